/* src/qpb_defs.svh */
`ifndef QPB_DEFS_SVH
`define QPB_DEFS_SVH
`define QPB_DATA_W 18
`define QPB_LANE_W 9
`define QPB_LANES 2
`define QPB_ADDR_W 20
`define QPB_BURST 4
`define QPB_WORD_W (`QPB_BURST * `QPB_DATA_W)
`define QPB_MASK_W (`QPB_BURST * `QPB_LANES)
`define QPB_DRAIN_W 4
`define QPB_DRAIN_EDGES 4'hA
`define QPB_BEAT_LAST 2'h3
`endif

/* src/qpb_pkg.sv */
`include "qpb_defs.svh"
package qpb_pkg;
	typedef struct packed {
		logic v;
		logic [`QPB_ADDR_W-1:0] a;
	} qpb_rec_t;

	typedef struct packed {
		logic v;
		logic [`QPB_WORD_W-1:0] d;
		logic [`QPB_MASK_W-1:0] m;
	} qpb_wrec_t;

	typedef struct packed {
		logic kclk_prev;
		qpb_rec_t [4:1] rs;
		qpb_rec_t [4:1] ws;
		logic [`QPB_DATA_W-1:0] q;
		logic q_oe;
		logic rvld;
		logic busy;
	} qpb_dev_st_t;

	typedef struct packed {
		logic kclk;
		logic [`QPB_DRAIN_W-1:0] drain;
		logic rd_n;
		logic wr_n;
		logic [`QPB_ADDR_W-1:0] addr;
		logic [`QPB_DATA_W-1:0] d;
		logic [`QPB_LANES-1:0] bl_n;
		logic last_rd;
		logic last_wr;
		qpb_wrec_t [4:1] cw;
		logic [1:0] beat;
		logic [`QPB_WORD_W-1:0] rdata;
		logic rvalid;
		logic rtaken;
		logic wtaken;
	} qpb_ctl_st_t;
endpackage

/* src/qpb_if.sv */
`timescale 1ns/1ps
`include "qpb_defs.svh"
interface qpb_if;
	logic kclk;
	logic rd_n;
	logic wr_n;
	logic [`QPB_ADDR_W-1:0] addr;
	logic [`QPB_DATA_W-1:0] d;
	logic byte_lane0_write_n;
	logic byte_lane1_write_n;
	logic [`QPB_DATA_W-1:0] q;
	logic q_oe;
	logic read_valid_flag;

	modport dev (
		input kclk, rd_n, wr_n, addr, d, byte_lane0_write_n, byte_lane1_write_n,
		output q, q_oe, read_valid_flag
	);

	modport ctl (
		output kclk, rd_n, wr_n, addr, d, byte_lane0_write_n, byte_lane1_write_n,
		input q, q_oe, read_valid_flag
	);
endinterface

/* src/qpb_dev.sv */
`timescale 1ns/1ps
`include "qpb_defs.svh"
module qpb_dev (
	// Clock and reset
	input wire logic clk_sys_in,
	input wire logic reset_n_in,
	// Link from the controller
	qpb_if.dev link,
	// Status
	output logic busy_out
);
	qpb_pkg::qpb_dev_st_t st_q;
	qpb_pkg::qpb_dev_st_t st_d;

	// The storage array has no reset; its contents are undefined until written.
	logic [`QPB_DATA_W-1:0] mem [0:(1 << `QPB_ADDR_W)-1];

	logic true_e;
	logic comp_e;
	logic idle;
	logic rd_ok;
	logic wr_ok;
	logic rd_go;
	logic [`QPB_ADDR_W-1:0] ra;
	logic mem_we;
	logic [`QPB_ADDR_W-1:0] mem_wa;
	logic [`QPB_DATA_W-1:0] mem_wd;
	logic [`QPB_LANES-1:0] mem_bm;
	logic [`QPB_DATA_W-1:0] rd_word;
	qpb_pkg::qpb_rec_t rnew;
	qpb_pkg::qpb_rec_t wnew;

	assign link.q = st_q.q;
	assign link.q_oe = st_q.q_oe;
	assign link.read_valid_flag = st_q.rvld;
	assign busy_out = st_q.busy;

	// Array write per lane; an aborted lane keeps its stored bits.
	always_ff @(posedge clk_sys_in)
	begin
		if (mem_we)
		begin
			for (int i = 0; i < `QPB_LANES; i++)
			begin
				if (!mem_bm[i])
				begin
					mem[mem_wa][i*`QPB_LANE_W +: `QPB_LANE_W] <= mem_wd[i*`QPB_LANE_W +: `QPB_LANE_W];
				end
			end
		end
	end

	// A beat written in the same slot as it is read is forwarded; a read whose slot comes
	// before the write beat of its address, still in flight, returns the old stored data.
	always_comb
	begin
		rd_word = mem[ra];
		if (mem_we && (mem_wa == ra))
		begin
			for (int i = 0; i < `QPB_LANES; i++)
			begin
				if (!mem_bm[i])
				begin
					rd_word[i*`QPB_LANE_W +: `QPB_LANE_W] = mem_wd[i*`QPB_LANE_W +: `QPB_LANE_W];
				end
			end
		end
	end

	always_comb
	begin
		st_d = st_q;
		st_d.kclk_prev = link.kclk;
		// Only transitions of the link clock move anything, so a stopped clock
		// freezes the sequencers and holds the outputs.
		true_e = link.kclk && !st_q.kclk_prev;
		comp_e = !link.kclk && st_q.kclk_prev;
		idle = !st_q.rs[1].v && !st_q.ws[1].v;
		rd_ok = 1'b0;
		wr_ok = 1'b0;
		rd_go = 1'b0;
		ra = st_q.rs[2].a;
		mem_we = 1'b0;
		mem_wa = st_q.ws[2].a;
		mem_wd = link.d;
		mem_bm = {link.byte_lane1_write_n, link.byte_lane0_write_n};
		rnew = '0;
		wnew = '0;
		if (true_e)
		begin
			rd_ok = !link.rd_n && !st_q.rs[1].v;
			wr_ok = !link.wr_n && !st_q.ws[1].v && !(idle && !link.rd_n);
			// Beats 0 and 2 land on true edges, two and three cycles after the command.
			if (st_q.rs[2].v)
			begin
				rd_go = 1'b1;
				ra = st_q.rs[2].a;
			end
			else if (st_q.rs[3].v)
			begin
				rd_go = 1'b1;
				ra = st_q.rs[3].a + `QPB_ADDR_W'(2);
			end
			if (st_q.ws[2].v)
			begin
				mem_we = 1'b1;
				mem_wa = st_q.ws[2].a;
			end
			else if (st_q.ws[3].v)
			begin
				mem_we = 1'b1;
				mem_wa = st_q.ws[3].a + `QPB_ADDR_W'(2);
			end
			st_d.rvld = st_q.rs[2].v;
			rnew.v = rd_ok;
			rnew.a = link.addr;
			wnew.v = wr_ok;
			wnew.a = link.addr;
			// Read and write pipelines are separate, so both may hold bursts at once.
			st_d.rs = {st_q.rs[3:1], rnew};
			st_d.ws = {st_q.ws[3:1], wnew};
		end
		else if (comp_e)
		begin
			// Beats 1 and 3 land on complement edges.
			if (st_q.rs[3].v)
			begin
				rd_go = 1'b1;
				ra = st_q.rs[3].a + `QPB_ADDR_W'(1);
			end
			else if (st_q.rs[4].v)
			begin
				rd_go = 1'b1;
				ra = st_q.rs[4].a + `QPB_ADDR_W'(3);
			end
			if (st_q.ws[3].v)
			begin
				mem_we = 1'b1;
				mem_wa = st_q.ws[3].a + `QPB_ADDR_W'(1);
			end
			else if (st_q.ws[4].v)
			begin
				mem_we = 1'b1;
				mem_wa = st_q.ws[4].a + `QPB_ADDR_W'(3);
			end
			st_d.rvld = st_q.rs[2].v || st_q.rs[3].v;
		end
		if (rd_go)
		begin
			st_d.q = rd_word;
			st_d.q_oe = 1'b1;
		end
		else if (true_e || comp_e)
		begin
			st_d.q_oe = 1'b0;
		end
		st_d.busy = (|{st_d.rs[1].v, st_d.rs[2].v, st_d.rs[3].v, st_d.rs[4].v})
			|| (|{st_d.ws[1].v, st_d.ws[2].v, st_d.ws[3].v, st_d.ws[4].v});
	end

	always_ff @(posedge clk_sys_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			st_q <= '0;
		end
		else
		begin
			st_q <= st_d;
		end
	end
endmodule

/* src/qpb_ctl.sv */
`timescale 1ns/1ps
`include "qpb_defs.svh"
module qpb_ctl (
	// Clock and reset
	input wire logic clk_sys_in,
	input wire logic reset_n_in,
	// Link to the memory
	qpb_if.ctl link,
	// Clock run request
	input wire logic run_in,
	// Read request and answer
	input wire logic rd_req_in,
	input wire logic [`QPB_ADDR_W-1:0] rd_addr_in,
	output logic rd_taken_out,
	output logic [`QPB_WORD_W-1:0] rd_data_out,
	output logic rd_valid_out,
	// Write request
	input wire logic wr_req_in,
	input wire logic [`QPB_ADDR_W-1:0] wr_addr_in,
	input wire logic [`QPB_WORD_W-1:0] wr_data_in,
	input wire logic [`QPB_MASK_W-1:0] wr_mask_n_in,
	output logic wr_taken_out
);
	qpb_pkg::qpb_ctl_st_t st_q;
	qpb_pkg::qpb_ctl_st_t st_d;

	logic run;
	logic rise;
	logic rd_ok;
	logic wr_ok;
	qpb_pkg::qpb_wrec_t wnew;

	assign link.kclk = st_q.kclk;
	assign link.rd_n = st_q.rd_n;
	assign link.wr_n = st_q.wr_n;
	assign link.addr = st_q.addr;
	assign link.d = st_q.d;
	assign link.byte_lane0_write_n = st_q.bl_n[0];
	assign link.byte_lane1_write_n = st_q.bl_n[1];
	assign rd_taken_out = st_q.rtaken;
	assign rd_data_out = st_q.rdata;
	assign rd_valid_out = st_q.rvalid;
	assign wr_taken_out = st_q.wtaken;

	always_comb
	begin
		st_d = st_q;
		st_d.rtaken = 1'b0;
		st_d.wtaken = 1'b0;
		st_d.rvalid = 1'b0;
		// The clock keeps toggling until every burst has drained.
		run = run_in || (st_q.drain != '0);
		rise = run && !st_q.kclk;
		rd_ok = 1'b0;
		wr_ok = 1'b0;
		wnew = '0;
		if (run)
		begin
			st_d.kclk = !st_q.kclk;
			if (st_q.drain != '0)
			begin
				st_d.drain = st_q.drain - `QPB_DRAIN_W'(1);
			end
		end
		if (rise)
		begin
			rd_ok = rd_req_in && !st_q.last_rd;
			// A write waits for an edge without a read, so it never meets the
			// idle read-wins case and follows a read by one cycle.
			wr_ok = wr_req_in && !st_q.last_wr && !rd_ok;
			st_d.rd_n = !rd_ok;
			st_d.wr_n = !wr_ok;
			st_d.addr = rd_ok ? rd_addr_in : wr_addr_in;
			st_d.last_rd = rd_ok;
			st_d.last_wr = wr_ok;
			st_d.rtaken = rd_ok;
			st_d.wtaken = wr_ok;
			if (rd_ok || wr_ok)
			begin
				st_d.drain = `QPB_DRAIN_EDGES;
			end
			wnew.v = wr_ok;
			wnew.d = wr_data_in;
			wnew.m = wr_mask_n_in;
			if (st_q.cw[2].v)
			begin
				st_d.d = st_q.cw[2].d[0 +: `QPB_DATA_W];
				st_d.bl_n = st_q.cw[2].m[0 +: `QPB_LANES];
			end
			else if (st_q.cw[3].v)
			begin
				st_d.d = st_q.cw[3].d[2*`QPB_DATA_W +: `QPB_DATA_W];
				st_d.bl_n = st_q.cw[3].m[2*`QPB_LANES +: `QPB_LANES];
			end
			else
			begin
				st_d.bl_n = '1;
			end
			st_d.cw = {st_q.cw[3:1], wnew};
		end
		else if (run)
		begin
			// Commands are only looked at on true edges; release them between.
			st_d.rd_n = 1'b1;
			st_d.wr_n = 1'b1;
			if (st_q.cw[3].v)
			begin
				st_d.d = st_q.cw[3].d[`QPB_DATA_W +: `QPB_DATA_W];
				st_d.bl_n = st_q.cw[3].m[`QPB_LANES +: `QPB_LANES];
			end
			else if (st_q.cw[4].v)
			begin
				st_d.d = st_q.cw[4].d[3*`QPB_DATA_W +: `QPB_DATA_W];
				st_d.bl_n = st_q.cw[4].m[3*`QPB_LANES +: `QPB_LANES];
			end
			else
			begin
				st_d.bl_n = '1;
			end
		end
		// The memory moves its output once per link edge and the link edge comes
		// every clock while running, so each driven cycle is one beat.
		if (link.q_oe)
		begin
			st_d.rdata = {link.q, st_q.rdata[`QPB_WORD_W-1:`QPB_DATA_W]};
			st_d.beat = st_q.beat + 2'h1;
			st_d.rvalid = (st_q.beat == `QPB_BEAT_LAST);
		end
	end

	always_ff @(posedge clk_sys_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			st_q <= '0;
			st_q.rd_n <= 1'b1;
			st_q.wr_n <= 1'b1;
			st_q.bl_n <= '1;
		end
		else
		begin
			st_q <= st_d;
		end
	end
endmodule

/* bench/qpb_sva.sv */
`timescale 1ns/1ps
module qpb_sva (
	// Clock and reset
	input wire logic clk_sys_in,
	input wire logic reset_n_in,
	// Link signals
	input wire logic kclk,
	input wire logic rd_n,
	input wire logic wr_n,
	input wire logic byte_lane0_write_n,
	input wire logic byte_lane1_write_n,
	input wire logic q_oe,
	input wire logic read_valid_flag
);
	logic kclk_q;
	// Outputs are registered one clock after the link edge that moves them,
	// so the read data history must reach eight clocks back.
	logic [7:0] rd_hist_q;
	logic [7:0] wr_hist_q;
	logic rd_cmd;
	logic wr_cmd;
	assign rd_cmd = kclk && !kclk_q && !rd_n;
	assign wr_cmd = kclk && !kclk_q && !wr_n;
	always_ff @(posedge clk_sys_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			kclk_q <= 1'b0;
			rd_hist_q <= 8'h00;
			wr_hist_q <= 8'h00;
		end
		else
		begin
			kclk_q <= kclk;
			rd_hist_q <= {rd_hist_q[6:0], rd_cmd};
			wr_hist_q <= {wr_hist_q[6:0], wr_cmd};
		end
	end
	default clocking cb @(posedge clk_sys_in);
	endclocking
	default disable iff (!reset_n_in);
	sequence rd_beats;
		q_oe [*4];
	endsequence
	sequence vld_window;
		read_valid_flag [*3] ##1 !read_valid_flag;
	endsequence
	AST_RD_BEATS: assert property (rd_cmd |-> ##5 rd_beats)
		else $error("read beats not driven");
	AST_RVLD: assert property (rd_cmd |-> ##4 vld_window)
		else $error("read valid flag misplaced");
	AST_OE_CAUSE: assert property (q_oe |-> |rd_hist_q[7:4])
		else $error("read data driven without a read");
	AST_MASK_CAUSE: assert property (!(byte_lane0_write_n && byte_lane1_write_n) |-> |wr_hist_q[6:3])
		else $error("lane mask active outside a write burst");
	AST_RD_GAP: assert property (rd_cmd |=> !rd_cmd [*3])
		else $error("reads too close");
	AST_WR_GAP: assert property (wr_cmd |=> !wr_cmd [*3])
		else $error("writes too close");
	AST_ONE_CMD: assert property (!(rd_cmd && wr_cmd))
		else $error("read and write on one edge");
	AST_SEL_EDGE: assert property ((!rd_n || !wr_n) |-> (kclk && !kclk_q))
		else $error("select low off the true edge");
	AST_CLK_RUN: assert property ((|rd_hist_q || |wr_hist_q) |-> (kclk != kclk_q))
		else $error("link clock stopped during a burst");
endmodule

/* bench/qpb_tb_top.sv */
`timescale 1ns/1ps
`include "qpb_defs.svh"
module qpb_tb_top;
	logic clk_sys_in = 1'b0;
	logic reset_n_in = 1'b0;
	logic rd_req = 1'b0;
	logic wr_req = 1'b0;
	logic [`QPB_ADDR_W-1:0] rd_addr = 20'h0_0000;
	logic [`QPB_ADDR_W-1:0] wr_addr = 20'h0_0000;
	logic [`QPB_WORD_W-1:0] wr_data = 72'h00_0000_0000_0000_0000;
	logic [`QPB_MASK_W-1:0] wr_mask = 8'hFF;
	logic run = 1'b1;
	logic kclk_seen;
	logic dev_busy;
	logic rd_taken;
	logic wr_taken;
	logic rd_valid;
	logic [`QPB_WORD_W-1:0] rd_data;
	logic [17:0] mem [logic [19:0]];
	int num_errors = 0;
	int comparisons = 0;
	always #12.5 clk_sys_in = ~clk_sys_in;
	qpb_if qpb_if_inst ();
	qpb_dev qpb_dev_inst (.clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in),
		.link(qpb_if_inst), .busy_out(dev_busy));
	qpb_ctl qpb_ctl_inst (.clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in),
		.link(qpb_if_inst), .run_in(run), .rd_req_in(rd_req), .rd_addr_in(rd_addr),
		.rd_taken_out(rd_taken), .rd_data_out(rd_data), .rd_valid_out(rd_valid),
		.wr_req_in(wr_req), .wr_addr_in(wr_addr), .wr_data_in(wr_data),
		.wr_mask_n_in(wr_mask), .wr_taken_out(wr_taken));
	qpb_sva qpb_sva_inst (.clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in),
		.kclk(qpb_if_inst.kclk), .rd_n(qpb_if_inst.rd_n), .wr_n(qpb_if_inst.wr_n),
		.byte_lane0_write_n(qpb_if_inst.byte_lane0_write_n),
		.byte_lane1_write_n(qpb_if_inst.byte_lane1_write_n),
		.q_oe(qpb_if_inst.q_oe), .read_valid_flag(qpb_if_inst.read_valid_flag));
	task automatic chk(input logic [71:0] got, input logic [71:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			num_errors++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic print_verdict;
		$display("comparisons %0d mismatches %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// The model is updated when the write request is raised, before it is taken, so reads see the newest data.
	task automatic wr(input logic [19:0] a, input logic [71:0] w, input logic [7:0] m);
		int n;
		n = 0;
		@(negedge clk_sys_in);
		wr_req = 1'b1;
		wr_addr = a;
		wr_data = w;
		wr_mask = m;
		for (int i = 0; i < 8; i++)
			if (!m[i])
				mem[a + 20'(i / 2)][9 * (i % 2) +: 9] = w[9 * i +: 9];
		while (wr_taken !== 1'b1 && n < 40)
		begin
			@(negedge clk_sys_in);
			n++;
		end
		chk({71'h0, wr_taken}, 72'h1);
		wr_req = 1'b0;
	endtask
	task automatic rd(input logic [19:0] a);
		logic [71:0] e;
		int n;
		for (int i = 0; i < 4; i++)
			e[18 * i +: 18] = mem[a + 20'(i)];
		n = 0;
		@(negedge clk_sys_in);
		rd_req = 1'b1;
		rd_addr = a;
		while (rd_taken !== 1'b1 && n < 40)
		begin
			@(negedge clk_sys_in);
			n++;
		end
		chk({71'h0, rd_taken}, 72'h1);
		rd_req = 1'b0;
		// The memory has registered the command one clock after it was taken.
		@(negedge clk_sys_in);
		chk({71'h0, dev_busy}, 72'h1);
		while (rd_valid !== 1'b1 && n < 80)
		begin
			@(negedge clk_sys_in);
			n++;
		end
		chk({71'h0, rd_valid}, 72'h1);
		chk(rd_data, e);
	endtask
	initial
	begin
		repeat (5) @(negedge clk_sys_in);
		reset_n_in = 1'b1;
		// The burst wraps past the top of the address space.
		wr(20'hF_FFFE, {18'h3_3333, 18'h2_2222, 18'h1_1111, 18'h0_4444}, 8'h00);
		rd(20'hF_FFFE);
		$display("test 1 done");
		wr(20'hF_FFFE, {18'h0_AAAA, 18'h1_5555, 18'h2_0F0F, 18'h3_F0F0}, 8'h9C);
		rd(20'hF_FFFE);
		$display("test 2 done");
		fork
			rd(20'hF_FFFE);
			wr(20'h0_0010, {4{18'h1_5A5A}}, 8'h00);
		join
		rd(20'h0_0010);
		$display("test 3 done");
		// Stop the link clock; twenty clocks later it must be halted with the memory idle, and the memory
		// must come back with its contents intact when it runs again.
		run = 1'b0;
		repeat (20) @(negedge clk_sys_in);
		kclk_seen = qpb_if_inst.kclk;
		repeat (8) @(negedge clk_sys_in);
		chk({71'h0, qpb_if_inst.kclk}, {71'h0, kclk_seen});
		chk({71'h0, dev_busy}, 72'h0);
		chk({71'h0, qpb_if_inst.q_oe}, 72'h0);
		run = 1'b1;
		rd(20'h0_0010);
		$display("test 4 done");
		print_verdict;
	end
	// Each test needs well under a hundred cycles, so this leaves a wide margin.
	initial
	begin
		#50us;
		num_errors++;
		print_verdict;
	end
endmodule
